/* File: pkg/hps_pkg.sv */
/*
  Shared constants and types for the homing sequencer: control word
  layout, homing method codes, the stall timing count and the enums.
  Assumes a 20 MHz control clock; positions are two's complement counts.
*/
package hps_pkg;
  localparam int CW_W     = 16;          // control word width
  localparam int HOME_BIT = 4;           // homing start request bit
  localparam int MW       = 8;           // method number width, signed

  // method numbers, two's complement
  localparam logic [MW-1:0] M_DOG_Z_F   = 8'hFF; // -1
  localparam logic [MW-1:0] M_DOG_Z_R   = 8'hDF; // -33
  localparam logic [MW-1:0] M_STOP_F    = 8'hFC; // -4
  localparam logic [MW-1:0] M_STOP_R    = 8'hDC; // -36
  localparam logic [MW-1:0] M_CNT_Z_F   = 8'hFE; // -2
  localparam logic [MW-1:0] M_CNT_Z_R   = 8'hDE; // -34
  localparam logic [MW-1:0] M_DOG_REF_F = 8'hFA; // -6
  localparam logic [MW-1:0] M_DOG_REF_R = 8'hDA; // -38
  localparam logic [MW-1:0] M_CNT_REF_F = 8'hF9; // -7
  localparam logic [MW-1:0] M_CNT_REF_R = 8'hD9; // -39
  localparam logic [MW-1:0] M_CRADLE_F  = 8'hF8; // -8
  localparam logic [MW-1:0] M_CRADLE_R  = 8'hD8; // -40
  localparam logic [MW-1:0] M_SW_Z_P    = 8'h03;
  localparam logic [MW-1:0] M_SW_CR_P   = 8'h04;
  localparam logic [MW-1:0] M_SW_Z_N    = 8'h05;
  localparam logic [MW-1:0] M_SW_CR_N   = 8'h06;
  localparam logic [MW-1:0] M_HS_Z      = 8'h07;
  localparam logic [MW-1:0] M_HS_CR     = 8'h08;

  // stopper: motion counts as stopped after this long without a count
  localparam int CLK_KHZ       = 20000;
  localparam int STALL_TIME_US = 100;
  localparam int STALL_CYC     = (STALL_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int SCW           = 12;   // stall counter width

  typedef enum {
    K_NONE, K_DOG_Z, K_STOP, K_CNT_Z, K_DOG_REF, K_CNT_REF, K_CRADLE
  } hps_kind_t;

  typedef enum {
    S_IDLE, S_SEEK, S_DOG_ON, S_COUNT, S_WAIT_Z, S_SHIFT, S_PUSH, S_FIX
  } hps_state_t;
endpackage : hps_pkg

/* File: design/hps_edge.sv */
/*
  Rising and falling edge detector, one per input bit.
  Assumes inputs already synchronous to mclk_i.
*/
`timescale 1ns/1ns
module hps_edge #(
  parameter int N = 3
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] level_i,
  output logic      [N-1:0] rise_o,
  output logic      [N-1:0] fall_o
);
  logic [N-1:0] prev_reg;

  if (N < 1) begin : g_chk
    $error("hps_edge needs at least one input");
  end

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        prev_reg[i] <= 1'b0;
      end else begin
        prev_reg[i] <= level_i[i];
      end
    end
    assign rise_o[i] = level_i[i] & ~prev_reg[i];
    assign fall_o[i] = ~level_i[i] & prev_reg[i];
  end
endmodule : hps_edge

/* File: design/hps_meter.sv */
/*
  Travel meter: latches the position on go_i and flags when the
  distance covered in the selected direction reaches the target.
  Assumes targets below half the position range.
*/
`timescale 1ns/1ns
module hps_meter #(
  parameter int PW = 32
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic          go_i,
  input  wire logic          rev_i,
  input  wire logic [PW-1:0] pos_i,
  input  wire logic [PW-1:0] target_i,
  output logic               reached_o
);
  logic [PW-1:0] start_reg;
  logic [PW-1:0] tgt_reg;
  logic          armed_reg;
  logic [PW-1:0] trav;

  if (PW < 8) begin : g_chk
    $error("hps_meter position width too small");
  end

  // distance counted along the direction of motion
  assign trav = rev_i ? (start_reg - pos_i) : (pos_i - start_reg);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_reg <= '0;
      tgt_reg   <= '0;
      armed_reg <= 1'b0;
      reached_o <= 1'b0;
    end else if (go_i) begin
      start_reg <= pos_i;
      tgt_reg   <= target_i;
      armed_reg <= 1'b1;
      reached_o <= 1'b0;
    end else begin
      // backward drift reads negative and never counts as reached
      reached_o <= armed_reg & ~trav[PW-1] & (trav >= tgt_reg);
    end
  end
endmodule : hps_meter

/* File: design/hps_home_seq.sv */
/*
  Home position return sequencer. Takes the homing request from the
  controller's control word, drives the motor, watches dog, index and
  stroke limits, and fixes the home point into the command position.
  Assumes all inputs synchronous to mclk_i and distances in counts.
*/
// Notes on behaviour
// - incremental system: home unknown after power-on
// - absolute system: position kept, homing unneeded
// - dog Z methods decelerate at dog front
// - after dog rear, first index (plus shift)
// - stopper methods: home where motion stops
// - count methods decelerate at dog front
// - count Z methods: index after set distance
// - dog rear ref: travel plus shift after rear
// - front ref: travel plus shift from front
// - cradle: first index after dog front
// - stroke end in methods 3-6 warns
`timescale 1ns/1ns
module hps_home_seq #(
  parameter int PW = 32
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic [hps_pkg::CW_W-1:0]  ctrl_word_i,
  input  wire logic [hps_pkg::MW-1:0]    method_i,
  input  wire logic                      abs_sys_i,
  input  wire logic                      dog_i,
  input  wire logic                      index_i,
  input  wire logic                      fwd_lim_i,
  input  wire logic                      rev_lim_i,
  input  wire logic [PW-1:0]             enc_pos_i,
  input  wire logic [PW-1:0]             travel_dist_i,
  input  wire logic [PW-1:0]             shift_dist_i,
  input  wire logic [PW-1:0]             home_coord_i,
  output logic                           run_fwd_o,
  output logic                           run_rev_o,
  output logic                           creep_o,
  output logic                           busy_o,
  output logic                           home_valid_o,
  output logic                           home_done_o,
  output logic                           cmd_load_o,
  output logic [PW-1:0]                  cmd_pos_o,
  output logic                           warn_o,
  output logic                           err_o
);
  import hps_pkg::*;

  hps_state_t     state_reg;
  hps_state_t     state_next;
  hps_kind_t      kind_reg;
  hps_kind_t      kind_dec;
  logic           rev_reg;
  logic           rev_dec;
  logic           warn_en_reg;
  logic           warn_en_dec;
  logic           run_reg;
  logic           boot_reg;
  logic [2:0]     rise;
  logic [2:0]     fall;
  logic           start_rise;
  logic           dog_rise;
  logic           dog_fall;
  logic           idx_rise;
  logic           meter_go;
  logic [PW-1:0]  meter_tgt;
  logic           meter_hit;
  logic           moving;
  logic           limit_hit;
  logic           accept;
  logic [PW-1:0]  pos_prev_reg;
  logic           still;
  logic [SCW-1:0] stall_cnt_reg;
  logic           stalled;

  if (PW < 8) begin : g_chk
    $error("hps_home_seq position width too small");
  end

  hps_edge #(.N(3)) u_edge (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .level_i ({ctrl_word_i[HOME_BIT], index_i, dog_i}),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  assign start_rise = rise[2];
  assign idx_rise   = rise[1];
  assign dog_rise   = rise[0];
  assign dog_fall   = fall[0];

  hps_meter #(.PW(PW)) u_meter (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .go_i      (meter_go),
    .rev_i     (rev_reg),
    .pos_i     (enc_pos_i),
    .target_i  (meter_tgt),
    .reached_o (meter_hit)
  );

  // method decode: kind, direction, and whether stroke end only warns
  always_comb begin
    kind_dec    = K_NONE;
    rev_dec     = 1'b0;
    warn_en_dec = 1'b0;
    case (method_i)
      M_DOG_Z_F, M_HS_Z: kind_dec = K_DOG_Z;
      M_DOG_Z_R: begin
        kind_dec = K_DOG_Z;
        rev_dec  = 1'b1;
      end
      M_SW_Z_P: begin
        kind_dec    = K_DOG_Z;
        warn_en_dec = 1'b1;
      end
      M_SW_Z_N: begin
        kind_dec    = K_DOG_Z;
        rev_dec     = 1'b1;
        warn_en_dec = 1'b1;
      end
      M_CRADLE_F, M_HS_CR: kind_dec = K_CRADLE;
      M_CRADLE_R: begin
        kind_dec = K_CRADLE;
        rev_dec  = 1'b1;
      end
      M_SW_CR_P: begin
        kind_dec    = K_CRADLE;
        warn_en_dec = 1'b1;
      end
      M_SW_CR_N: begin
        kind_dec    = K_CRADLE;
        rev_dec     = 1'b1;
        warn_en_dec = 1'b1;
      end
      M_STOP_F: kind_dec = K_STOP;
      M_STOP_R: begin
        kind_dec = K_STOP;
        rev_dec  = 1'b1;
      end
      M_CNT_Z_F: kind_dec = K_CNT_Z;
      M_CNT_Z_R: begin
        kind_dec = K_CNT_Z;
        rev_dec  = 1'b1;
      end
      M_DOG_REF_F: kind_dec = K_DOG_REF;
      M_DOG_REF_R: begin
        kind_dec = K_DOG_REF;
        rev_dec  = 1'b1;
      end
      M_CNT_REF_F: kind_dec = K_CNT_REF;
      M_CNT_REF_R: begin
        kind_dec = K_CNT_REF;
        rev_dec  = 1'b1;
      end
      default: kind_dec = K_NONE;
    endcase
  end

  assign accept = (state_reg == S_IDLE) & start_rise & ~boot_reg
                  & (kind_dec != K_NONE);
  assign moving = (state_reg != S_IDLE) & (state_reg != S_FIX);
  // only the limit ahead of the motion ends the run
  assign limit_hit = moving & (rev_reg ? rev_lim_i : fwd_lim_i);
  assign still     = (enc_pos_i == pos_prev_reg);
  assign stalled   = still & (stall_cnt_reg == SCW'(STALL_CYC - 1));

  always_comb begin
    state_next = state_reg;
    meter_go   = 1'b0;
    meter_tgt  = travel_dist_i;
    case (state_reg)
      S_IDLE: begin
        if (accept) begin
          state_next = (kind_dec == K_STOP) ? S_PUSH : S_SEEK;
        end
      end
      S_SEEK: begin
        if (dog_rise) begin
          case (kind_reg)
            K_CNT_Z: begin
              meter_go   = 1'b1;
              state_next = S_COUNT;
            end
            K_CNT_REF: begin
              meter_go   = 1'b1;
              meter_tgt  = travel_dist_i + shift_dist_i;
              state_next = S_COUNT;
            end
            K_CRADLE: state_next = S_WAIT_Z;
            default:  state_next = S_DOG_ON;
          endcase
        end
      end
      S_DOG_ON: begin
        if (dog_fall) begin
          if (kind_reg == K_DOG_Z) begin
            state_next = S_WAIT_Z;
          end else begin
            meter_go   = 1'b1;
            meter_tgt  = travel_dist_i + shift_dist_i;
            state_next = S_SHIFT;
          end
        end
      end
      S_COUNT: begin
        if (meter_hit) begin
          state_next = (kind_reg == K_CNT_Z) ? S_WAIT_Z : S_FIX;
        end
      end
      S_WAIT_Z: begin
        if (idx_rise) begin
          if (shift_dist_i == '0) begin
            state_next = S_FIX;
          end else begin
            meter_go   = 1'b1;
            meter_tgt  = shift_dist_i;
            state_next = S_SHIFT;
          end
        end
      end
      S_SHIFT: begin
        if (meter_hit) begin
          state_next = S_FIX;
        end
      end
      S_PUSH: begin
        if (stalled) begin
          state_next = S_FIX;
        end
      end
      S_FIX: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
    if (limit_hit) begin
      state_next = S_IDLE;
      meter_go   = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // method latched for the whole run; direction drives motion and meter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      kind_reg    <= K_NONE;
      rev_reg     <= 1'b0;
      warn_en_reg <= 1'b0;
    end else if (accept) begin
      kind_reg    <= kind_dec;
      rev_reg     <= rev_dec;
      warn_en_reg <= warn_en_dec;
    end
  end

  // motion and speed requests; creep once the dog is met or pushing
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      creep_o <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      run_reg <= (state_next != S_IDLE) & (state_next != S_FIX);
      creep_o <= (state_next != S_IDLE) & (state_next != S_SEEK)
                 & (state_next != S_FIX);
      busy_o  <= (state_next != S_IDLE);
    end
  end

  assign run_fwd_o = run_reg & ~rev_reg;
  assign run_rev_o = run_reg & rev_reg;

  // stopper detection: no encoder count for the stall time
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_prev_reg  <= '0;
      stall_cnt_reg <= '0;
    end else begin
      pos_prev_reg <= enc_pos_i;
      if (state_reg != S_PUSH || !still) begin
        stall_cnt_reg <= '0;
      end else if (!stalled) begin
        stall_cnt_reg <= stall_cnt_reg + SCW'(1);
      end
    end
  end

  // boot flag lets the strap be sampled after reset release
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      home_valid_o <= 1'b0;
      home_done_o  <= 1'b0;
      cmd_load_o   <= 1'b0;
      cmd_pos_o    <= '0;
    end else begin
      home_done_o <= (state_reg == S_FIX);
      cmd_load_o  <= 1'b0;
      if (boot_reg) begin
        home_valid_o <= abs_sys_i;
        if (abs_sys_i) begin
          cmd_pos_o  <= enc_pos_i;
          cmd_load_o <= 1'b1;
        end
      end else if (state_reg == S_FIX) begin
        home_valid_o <= 1'b1;
        cmd_pos_o    <= home_coord_i;
        cmd_load_o   <= 1'b1;
      end else if (accept) begin
        home_valid_o <= 1'b0;   // a new run voids the old home
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_o <= 1'b0;
      err_o  <= 1'b0;
    end else if (limit_hit) begin
      warn_o <= warn_en_reg;
      err_o  <= ~warn_en_reg;
    end else if (state_reg == S_IDLE && start_rise && !boot_reg) begin
      warn_o <= 1'b0;
      err_o  <= (kind_dec == K_NONE);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    accept;
  endsequence

  sequence s_rear_z;
    state_reg == S_DOG_ON && dog_fall && kind_reg == K_DOG_Z && !limit_hit;
  endsequence

  sequence s_cnt_z;
    state_reg == S_COUNT && meter_hit && kind_reg == K_CNT_Z && !limit_hit;
  endsequence

  start_busy_a: assert property (s_take |=> busy_o && run_reg)
    else $error("homing request not taken");
  inc_boot_a: assert property (boot_reg && !abs_sys_i
                               |=> !home_valid_o)
    else $error("home valid after power-on in incremental mode");
  abs_boot_a: assert property (boot_reg && abs_sys_i
                               |=> home_valid_o
                               && cmd_pos_o == $past(enc_pos_i))
    else $error("absolute position not kept");
  dog_decel_a: assert property (state_reg == S_SEEK && dog_rise
                                && !limit_hit |=> creep_o && busy_o)
    else $error("no deceleration at dog front");
  rear_z_a: assert property (s_rear_z |=> state_reg == S_WAIT_Z)
    else $error("index wait not entered after dog rear");
  stop_fix_a: assert property (state_reg == S_PUSH && !still
                               |=> state_reg != S_FIX)
    else $error("stopper home fixed while moving");
  count_z_a: assert property (s_cnt_z |=> state_reg == S_WAIT_Z)
    else $error("count method skipped index wait");
  cradle_a: assert property (state_reg == S_SEEK && dog_rise
                             && !limit_hit && kind_reg == K_CRADLE
                             |=> state_reg == S_WAIT_Z)
    else $error("cradle method missed index wait");
  lim_warn_a: assert property (limit_hit && warn_en_reg
                               |=> warn_o && !err_o && !busy_o)
    else $error("stroke end warning missing");
  fix_load_a: assert property (state_reg == S_FIX
                               |=> home_done_o && cmd_load_o && home_valid_o
                               && cmd_pos_o == $past(home_coord_i))
    else $error("home coordinate not loaded");
  // direction judged from the method code itself, not the latched flag
  dir_run_a: assert property (s_take
                              |=> run_fwd_o != run_rev_o
                              && run_rev_o == $past(method_i[MW-1]
                              ? !method_i[5]
                              : (method_i == M_SW_Z_N
                                 || method_i == M_SW_CR_N)))
    else $error("motion direction differs from method");
endmodule : hps_home_seq

/* File: test/hps_axis_model.sv */
/*
  Axis mechanics behind the sequencer: one count per cycle while a
  run request is up, dog cam over a fixed window, index every 16 counts.
  Assumes the bench presets the position and commands the stall.
*/
`timescale 1ns/1ns
module hps_axis_model #(
  parameter int PW     = 16,
  parameter int DOG_LO = 100,
  parameter int DOG_HI = 140
) (
  input  wire logic          mclk_i,
  input  wire logic          run_fwd_i,
  input  wire logic          run_rev_i,
  input  wire logic          stall_i,
  input  wire logic          load_i,
  input  wire logic [PW-1:0] load_val_i,
  output logic      [PW-1:0] enc_pos_o,
  output logic               dog_o,
  output logic               index_o
);
  logic [PW-1:0] pos_reg;

  // no reset: an encoder keeps counting across a drive reset
  always_ff @(posedge mclk_i) begin
    if (load_i) begin
      pos_reg <= load_val_i;
    end else if (!stall_i && run_fwd_i) begin
      pos_reg <= pos_reg + 1'b1;
    end else if (!stall_i && run_rev_i) begin
      pos_reg <= pos_reg - 1'b1;
    end
  end

  assign enc_pos_o = pos_reg;
  assign dog_o     = (int'(pos_reg) >= DOG_LO) && (int'(pos_reg) <= DOG_HI);
  assign index_o   = (pos_reg[3:0] == 4'h8);
endmodule : hps_axis_model

/* File: test/testbench.sv */
/*
  Self-checking bench for the homing sequencer: acts as the controller,
  runs every method against the axis model, then stopper, limit and
  reset cases. Assumes hps_pkg and the axis model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import hps_pkg::*;
  localparam int            PW   = 16;
  localparam logic [PW-1:0] HOME = 16'h0A5A;

  logic            mclk_i = 1'b0;
  logic            rst_i  = 1'b1;
  logic [CW_W-1:0] ctrl_word = '0;
  logic [MW-1:0]   method = '0;
  logic            abs_sys = 1'b0;
  logic            fwd_lim = 1'b0;
  logic            rev_lim = 1'b0;
  logic            stall = 1'b0;
  logic            load = 1'b1;
  logic [PW-1:0]   load_val = '0;
  logic [PW-1:0]   travel = '0;
  logic [PW-1:0]   shift = '0;
  logic [PW-1:0]   enc_pos, cmd_pos;
  logic            dog, index, run_fwd, run_rev, creep, busy;
  logic            home_valid, home_done, cmd_load, warn, err;
  int              mismatches = 0;
  int              check_count = 0;
  int              creep_at;

  always #25 mclk_i = ~mclk_i;

  hps_axis_model #(.PW(PW)) axis (
    .mclk_i(mclk_i), .run_fwd_i(run_fwd), .run_rev_i(run_rev),
    .stall_i(stall), .load_i(load), .load_val_i(load_val),
    .enc_pos_o(enc_pos), .dog_o(dog), .index_o(index));

  hps_home_seq #(.PW(PW)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .ctrl_word_i(ctrl_word),
    .method_i(method), .abs_sys_i(abs_sys), .dog_i(dog),
    .index_i(index), .fwd_lim_i(fwd_lim), .rev_lim_i(rev_lim),
    .enc_pos_i(enc_pos), .travel_dist_i(travel), .shift_dist_i(shift),
    .home_coord_i(HOME), .run_fwd_o(run_fwd), .run_rev_o(run_rev),
    .creep_o(creep), .busy_o(busy), .home_valid_o(home_valid),
    .home_done_o(home_done), .cmd_load_o(cmd_load), .cmd_pos_o(cmd_pos),
    .warn_o(warn), .err_o(err));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // bit 4 must fall and rise again for every new run
  task automatic start_run(input logic [MW-1:0] m, input logic [PW-1:0] p0);
    @(negedge mclk_i);
    load = 1'b1;
    load_val = p0;
    method = m;
    ctrl_word = '0;
    @(negedge mclk_i);
    load = 1'b0;
    ctrl_word[HOME_BIT] = 1'b1;
    @(negedge mclk_i);
  endtask : start_run

  task automatic wait_done(input int lim, output int n);
    n = 0;
    creep_at = -1;
    while (home_done !== 1'b1 && n < lim) begin
      if (creep === 1'b1 && creep_at < 0) creep_at = int'(enc_pos);
      @(negedge mclk_i);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_done

  // ideal: home position in counts; slow: check that creep starts within 4 counts of the dog front
  task automatic home_run(input logic [MW-1:0] m, input logic [PW-1:0] p0,
                          input logic fwd, input logic [PW-1:0] t,
                          input logic [PW-1:0] s, input int ideal,
                          input logic slow);
    int n, d, c;
    travel = t;
    shift = s;
    start_run(m, p0);
    chk({busy, run_fwd, run_rev}, {1'b1, fwd, ~fwd});
    wait_done(4000, n);
    d = fwd ? int'(enc_pos) - ideal : ideal - int'(enc_pos);
    c = fwd ? creep_at - 100 : 140 - creep_at;
    chk(d >= 0 && d <= 6, 1);
    if (slow) chk(c >= 0 && c <= 4, 1);
    chk({cmd_pos, cmd_load, home_valid}, {HOME, 2'b11});
    @(negedge mclk_i);
    chk({busy, run_fwd, run_rev, home_done}, 4'h0);
  endtask : home_run

  task automatic stop_run(input logic [MW-1:0] m, input logic fwd);
    int n;
    start_run(m, 16'd50);
    chk({run_fwd, run_rev, creep}, {fwd, ~fwd, 1'b1});
    repeat (5) @(negedge mclk_i);
    stall = 1'b1;
    wait_done(2100, n);
    chk(n >= 1999 && n <= 2003, 1);
    chk({cmd_pos, home_valid}, {HOME, 1'b1});
    stall = 1'b0;
  endtask : stop_run

  // the limit ahead of the motion is raised, forward or reverse
  task automatic lim_run(input logic [MW-1:0] m, input logic fwd,
                         input logic w);
    start_run(m, fwd ? 16'h0000 : 16'h00FA);
    repeat (10) @(negedge mclk_i);
    fwd_lim = fwd;
    rev_lim = ~fwd;
    repeat (3) @(negedge mclk_i);
    chk({busy, run_fwd, run_rev, warn, err}, {3'b000, w, ~w});
    fwd_lim = 1'b0;
    rev_lim = 1'b0;
  endtask : lim_run

  task automatic abs_boot;
    @(negedge mclk_i);
    load_val = 16'h0123;
    load = 1'b1;
    rst_i = 1'b1;
    abs_sys = 1'b1;
    repeat (2) @(negedge mclk_i);
    load = 1'b0;
    rst_i = 1'b0;
    @(negedge mclk_i);
    chk({home_valid, cmd_load, cmd_pos}, {2'b11, 16'h0123});
  endtask : abs_boot

  initial begin
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk({home_valid, busy}, 2'b00);
    home_run(M_DOG_Z_F, 16'd0, 1'b1, 16'd0, 16'd0, 152, 1'b1);
    home_run(M_DOG_Z_F, 16'd0, 1'b1, 16'd0, 16'd10, 162, 1'b1);
    home_run(M_DOG_Z_R, 16'd250, 1'b0, 16'd0, 16'd0, 88, 1'b1);
    home_run(M_CNT_Z_F, 16'd0, 1'b1, 16'd20, 16'd0, 136, 1'b1);
    home_run(M_CNT_Z_R, 16'd250, 1'b0, 16'd24, 16'd0, 104, 1'b1);
    home_run(M_DOG_REF_F, 16'd0, 1'b1, 16'd20, 16'd5, 166, 1'b1);
    home_run(M_DOG_REF_R, 16'd250, 1'b0, 16'd20, 16'd5, 74, 1'b1);
    home_run(M_CNT_REF_F, 16'd0, 1'b1, 16'd20, 16'd5, 125, 1'b1);
    home_run(M_CNT_REF_R, 16'd250, 1'b0, 16'd20, 16'd5, 115, 1'b1);
    home_run(M_CRADLE_F, 16'd0, 1'b1, 16'd0, 16'd0, 104, 1'b0);
    home_run(M_CRADLE_R, 16'd250, 1'b0, 16'd0, 16'd0, 136, 1'b0);
    home_run(M_SW_Z_P, 16'd0, 1'b1, 16'd0, 16'd0, 152, 1'b1);
    home_run(M_SW_CR_P, 16'd0, 1'b1, 16'd0, 16'd0, 104, 1'b0);
    home_run(M_SW_Z_N, 16'd250, 1'b0, 16'd0, 16'd0, 88, 1'b1);
    home_run(M_SW_CR_N, 16'd250, 1'b0, 16'd0, 16'd0, 136, 1'b0);
    home_run(M_HS_Z, 16'd0, 1'b1, 16'd0, 16'd0, 152, 1'b1);
    home_run(M_HS_CR, 16'd0, 1'b1, 16'd0, 16'd0, 104, 1'b0);
    stop_run(M_STOP_F, 1'b1);
    stop_run(M_STOP_R, 1'b0);
    lim_run(M_SW_Z_P, 1'b1, 1'b1);
    lim_run(M_SW_Z_N, 1'b0, 1'b1);
    lim_run(M_DOG_Z_F, 1'b1, 1'b0);
    start_run(8'h00, 16'd0);
    chk({busy, err}, 2'b01);
    abs_boot();
    wrap_up();
  end
endmodule : testbench
